// ---- shared/sdf_consts.svh ----
// constants for the stereo converter digital front end: fields, reset values, counts
`ifndef SDF_CONSTS_SVH
`define SDF_CONSTS_SVH

// ****************************************************************
// control word layout
// ****************************************************************
`define SDF_WORD_BITS 16
`define SDF_SEL_LO 9
`define SDF_SEL_HI 10
`define SDF_REG_LEFT 2'h0
`define SDF_REG_RIGHT 2'h1
`define SDF_REG_CTL2 2'h2
`define SDF_REG_CTL3 2'h3
`define SDF_UPD_BIT 8
`define SDF_R2_MUTE 0
`define SDF_R2_DM_LO 1
`define SDF_R2_DM_HI 2
`define SDF_R2_FORCE 3
`define SDF_R2_IZD 4
`define SDF_R3_FMT 0
`define SDF_R3_POL 1
`define SDF_R3_WLEN 2
`define SDF_R3_ATC 3

// ****************************************************************
// reset values
// ****************************************************************
`define SDF_STEPS_RST 8'hFF
`define SDF_CTL2_RST 5'h00
`define SDF_CTL3_RST 4'h0

// ****************************************************************
// clock ratios, alignment window, zero run, gain steps and bipolar zero code
// ****************************************************************
`define SDF_RATIO_LO 256
`define SDF_RATIO_HI 384
`define SDF_RATIO_SPLIT 320
`define SDF_ALIGN_TOL_BCK 6
`define SDF_BCK_PER_FRAME 64
`define SDF_ZERO_RUN 65536
`define SDF_STEP_MAX 8'hFF
`define SDF_GAIN_FULL 9'h100
`define SDF_BPZ 18'h00000

`endif

// ---- shared/sdf_pkg.sv ----
// types for the stereo converter digital front end
package sdf_pkg;

	typedef logic signed [17:0] sdf_sample_t;

	typedef enum logic {
		align_locked,
		align_resync
	} sdf_align_t;

	// system clock domain state
	typedef struct packed {
		logic xti_s1;
		logic xti_s2;
		logic xti_d;
		logic lr_s1;
		logic lr_s2;
		logic lr_d;
		logic mc_s1;
		logic mc_s2;
		logic mc_d;
		logic md_s1;
		logic md_s2;
		logic ml_s1;
		logic ml_s2;
		logic ml_d;
		logic rx_s1;
		logic rx_s2;
		logic zf_s1;
		logic zf_s2;
		logic tog_s1;
		logic tog_s2;
		logic tog_d;
		logic [15:0] shift;
		logic [7:0] left_steps;
		logic [7:0] right_steps;
		logic [7:0] act_left;
		logic [7:0] act_right;
		logic [4:0] ctl2;
		logic [3:0] ctl3;
		logic [9:0] xti_cnt;
		logic [8:0] phase;
		logic sysclk_384;
		sdf_align_t align;
		logic [8:0] gain_left;
		logic [8:0] gain_right;
		sdf_sample_t out_left;
		sdf_sample_t out_right;
		logic valid;
		logic bipolar_zero_code;
		logic mod_conn;
		logic zero_oe_n;
	} sdf_core_t;

	// bit clock domain state
	typedef struct packed {
		logic rst_s1;
		logic rst_s2;
		logic [2:0] cfg_s1;
		logic [2:0] cfg_s2;
		logic lr_d;
		logic [17:0] sreg;
		logic [4:0] cnt;
		sdf_sample_t left_smp;
		sdf_sample_t right_smp;
		logic tog;
		logic l_zero;
		logic r_zero;
		logic [16:0] zcnt;
		logic zflag;
	} sdf_link_t;

endpackage : sdf_pkg

// ---- design/sdf_front_end.sv ----
// digital front end of a stereo delta-sigma converter: audio input, clock check, control port, zero flag
//
// Contract
// - system clock is 256 or 384 fs, auto-detected
// - realign when word clock drifts beyond six bits
// - hold outputs at mid-supply while realigning
// - zero flag low after 65536 zero bit clocks
// - zero flag open drain, released on nonzero
// - serial audio, right-justified or I2S, 16/18 bits
// - control port: shift clock, data, latch
// - 16-bit words, bits 10:9 select register
// - latch falling edge loads addressed register
// - gain y/256, step 255 means unity, 0 mutes
// - left update bit applies new attenuation
// - either update bit updates both channels together
// - register 1 holds right steps and update
// - register 2 bit 0 soft-mutes the output
// - register 2 bits 2:1 pick de-emphasis
// - force bit holds output at bipolar zero
// - zero detect enable forces zero after run
// - zero detect off keeps converting zero input
// - reset pin low forces zero, ignores port
// - register 3 bit 0 selects I2S format
// - register 3 bit 1 swaps word clock polarity
// - register 3 bit 2 selects 18-bit words
// - register 3 bit 3 shares left attenuation
`timescale 1ns/1ps
`default_nettype none
`include "sdf_consts.svh"

module sdf_front_end #(
	parameter int ZERO_RUN = `SDF_ZERO_RUN
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic bit_clock_in,
	input wire logic word_clock_in,
	input wire logic audio_data_in,
	input wire logic crystal_in,
	input wire logic control_shift_clock,
	input wire logic control_serial_data,
	input wire logic control_latch,
	input wire logic external_reset_n,
	output sdf_pkg::sdf_sample_t left_sample,
	output sdf_pkg::sdf_sample_t right_sample,
	output logic sample_valid,
	output logic bipolar_zero_hold,
	output logic modulator_connected,
	output logic soft_mute,
	output logic [1:0] deemph_select,
	output logic sysclk_384,
	output logic resync_active,
	output logic zero_flag_out,
	output logic zero_flag_oe_n
);
	import sdf_pkg::*;

	// ****************************************************************
	// helpers
	// ****************************************************************
	function automatic sdf_sample_t sdf_scale(input sdf_sample_t s, input logic [8:0] g);
		logic signed [27:0] p;
		p = s * $signed({1'b0, g});
		return p[25:8];
	endfunction : sdf_scale

	function automatic logic [8:0] sdf_ramp(input logic [8:0] cur, input logic [8:0] tgt);
		logic [8:0] r;
		r = cur;
		if (cur < tgt) begin
			r = cur + 9'h001;
		end else if (cur > tgt) begin
			r = cur - 9'h001;
		end
		return r;
	endfunction : sdf_ramp

	// step 255 stands for unity so that full scale needs no ninth bit in the register
	function automatic logic [8:0] sdf_gain(input logic [7:0] x);
		return (x == `SDF_STEP_MAX) ? `SDF_GAIN_FULL : {1'b0, x};
	endfunction : sdf_gain

	function automatic sdf_sample_t sdf_extend(input logic [17:0] v, input logic wide);
		return wide ? sdf_sample_t'(v) : sdf_sample_t'({{2{v[15]}}, v[15:0]});
	endfunction : sdf_extend

	sdf_core_t c;
	sdf_core_t n;
	sdf_link_t b;
	sdf_link_t m;

	// ****************************************************************
	// bit clock domain: audio capture and zero run
	// ****************************************************************
	always_comb begin
		logic fmt;
		logic pol;
		logic wide;
		logic edge_seen;
		logic was_left;
		logic now_left;
		logic [17:0] sh;
		logic [4:0] width;
		logic [4:0] cnt_next;
		logic cap;
		logic cap_left;
		sdf_sample_t val;
		fmt = b.cfg_s2[`SDF_R3_FMT];
		pol = b.cfg_s2[`SDF_R3_POL];
		wide = b.cfg_s2[`SDF_R3_WLEN];
		edge_seen = word_clock_in ^ b.lr_d;
		// normal format has left on high, I2S on low; polarity bit swaps either
		was_left = b.lr_d ^ pol ^ fmt;
		now_left = word_clock_in ^ pol ^ fmt;
		sh = {b.sreg[16:0], audio_data_in};
		width = wide ? 5'h12 : 5'h10;
		cnt_next = (b.cnt == 5'h1F) ? b.cnt : b.cnt + 5'h01;
		cap = 1'b0;
		cap_left = 1'b0;
		val = `SDF_BPZ;
		m = b;
		m.rst_s1 = rst_n;
		m.rst_s2 = b.rst_s1;
		m.cfg_s1 = c.ctl3[2:0];
		m.cfg_s2 = b.cfg_s1;
		m.lr_d = word_clock_in;
		m.sreg = sh;
		m.cnt = edge_seen ? 5'h00 : cnt_next;

		// ****************************************************************
		// word capture
		// ****************************************************************
		if (!fmt) begin
			// right-justified: the word ends on the bit before the word clock edge
			if (edge_seen) begin
				cap = 1'b1;
				cap_left = was_left;
				val = sdf_extend(b.sreg, wide);
			end
		end else begin
			// I2S: msb one bit after the edge, take the first width bits
			if (!edge_seen && cnt_next == width) begin
				cap = 1'b1;
				cap_left = now_left;
				val = sdf_extend(sh, wide);
			end
		end
		if (cap) begin
			if (cap_left) begin
				m.left_smp = val;
				m.l_zero = (val == `SDF_BPZ);
			end else begin
				m.right_smp = val;
				m.r_zero = (val == `SDF_BPZ);
				m.tog = ~b.tog;
			end
		end

		// ****************************************************************
		// zero run
		// ****************************************************************
		if (cap && val != `SDF_BPZ) begin
			m.zcnt = 17'h00000;
			m.zflag = 1'b0;
		end else if (m.l_zero && m.r_zero && !b.zflag) begin
			m.zcnt = b.zcnt + 17'h00001;
			if (b.zcnt == 17'(ZERO_RUN - 1)) begin
				m.zflag = 1'b1;
			end
		end

		// ****************************************************************
		// link reset
		// ****************************************************************
		if (!b.rst_s2) begin
			m.lr_d = 1'b0;
			m.sreg = 18'h00000;
			m.cnt = 5'h00;
			m.left_smp = `SDF_BPZ;
			m.right_smp = `SDF_BPZ;
			m.tog = 1'b0;
			m.l_zero = 1'b0;
			m.r_zero = 1'b0;
			m.zcnt = 17'h00000;
			m.zflag = 1'b0;
		end
	end

	always_ff @(posedge bit_clock_in) begin
		b <= m;
	end

	// ****************************************************************
	// system clock domain: clock check, control port, output stage
	// ****************************************************************
	always_comb begin
		logic xti_rise;
		logic lr_rise;
		logic mc_rise;
		logic ml_fall;
		logic tog_chg;
		logic [8:0] ratio;
		logic [8:0] tol;
		logic [8:0] dev;
		logic [1:0] sel;
		logic [7:0] right_eff;
		logic [8:0] tgt_l;
		logic [8:0] tgt_r;
		logic zero_force;
		xti_rise = c.xti_s2 & ~c.xti_d;
		lr_rise = c.lr_s2 & ~c.lr_d;
		mc_rise = c.mc_s2 & ~c.mc_d;
		ml_fall = ~c.ml_s2 & c.ml_d;
		tog_chg = c.tog_s2 ^ c.tog_d;
		ratio = c.sysclk_384 ? 9'(`SDF_RATIO_HI) : 9'(`SDF_RATIO_LO);
		tol = 9'((`SDF_ALIGN_TOL_BCK * int'(ratio)) / `SDF_BCK_PER_FRAME);
		dev = (c.phase < (ratio >> 1)) ? c.phase : ratio - c.phase;
		sel = {c.shift[`SDF_SEL_HI], c.shift[`SDF_SEL_LO]};
		right_eff = c.ctl3[`SDF_R3_ATC] ? c.act_left : c.act_right;
		tgt_l = c.ctl2[`SDF_R2_MUTE] ? 9'h000 : sdf_gain(c.act_left);
		tgt_r = c.ctl2[`SDF_R2_MUTE] ? 9'h000 : sdf_gain(right_eff);

		// ****************************************************************
		// input synchronisers
		// ****************************************************************
		n = c;
		n.xti_s1 = crystal_in;
		n.xti_s2 = c.xti_s1;
		n.xti_d = c.xti_s2;
		n.lr_s1 = word_clock_in;
		n.lr_s2 = c.lr_s1;
		n.lr_d = c.lr_s2;
		n.mc_s1 = control_shift_clock;
		n.mc_s2 = c.mc_s1;
		n.mc_d = c.mc_s2;
		n.md_s1 = control_serial_data;
		n.md_s2 = c.md_s1;
		n.ml_s1 = control_latch;
		n.ml_s2 = c.ml_s1;
		n.ml_d = c.ml_s2;
		n.rx_s1 = external_reset_n;
		n.rx_s2 = c.rx_s1;
		n.zf_s1 = b.zflag;
		n.zf_s2 = c.zf_s1;
		n.tog_s1 = b.tog;
		n.tog_s2 = c.tog_s1;
		n.tog_d = c.tog_s2;

		// ****************************************************************
		// clock check
		// ****************************************************************
		// crystal edges counted per frame give the ratio; phase runs modulo that ratio
		if (xti_rise) begin
			n.xti_cnt = (c.xti_cnt == 10'h3FF) ? c.xti_cnt : c.xti_cnt + 10'h001;
			n.phase = (c.phase == ratio - 9'h001) ? 9'h000 : c.phase + 9'h001;
		end
		if (lr_rise) begin
			n.sysclk_384 = (c.xti_cnt > 10'(`SDF_RATIO_SPLIT));
			n.xti_cnt = 10'h000;
			if (dev > tol) begin
				n.phase = 9'h000;
				n.align = align_resync;
			end else begin
				n.align = align_locked;
			end
		end

		// ****************************************************************
		// control port
		// ****************************************************************
		// port is dead while the reset pin is low; shifted bits are dropped too
		if (c.rx_s2) begin
			if (mc_rise) begin
				n.shift = {c.shift[14:0], c.md_s2};
			end
			if (ml_fall) begin
				case (sel)
					`SDF_REG_LEFT: begin
						n.left_steps = c.shift[7:0];
						if (c.shift[`SDF_UPD_BIT]) begin
							n.act_left = c.shift[7:0];
							n.act_right = c.right_steps;
						end
					end
					`SDF_REG_RIGHT: begin
						n.right_steps = c.shift[7:0];
						if (c.shift[`SDF_UPD_BIT]) begin
							n.act_right = c.shift[7:0];
							n.act_left = c.left_steps;
						end
					end
					`SDF_REG_CTL2: begin
						n.ctl2 = c.shift[4:0];
					end
					`SDF_REG_CTL3: begin
						n.ctl3 = c.shift[3:0];
					end
					default: begin
						n.ctl3 = c.ctl3;
					end
				endcase
			end
		end

		// ****************************************************************
		// output stage
		// ****************************************************************
		zero_force = c.ctl2[`SDF_R2_IZD] & c.zf_s2;
		n.mod_conn = ~(c.ctl2[`SDF_R2_FORCE] | zero_force | ~c.rx_s2);
		n.bipolar_zero_code = ~n.mod_conn | (c.align == align_resync);
		n.zero_oe_n = ~c.zf_s2;
		n.valid = 1'b0;

		// ****************************************************************
		// sample hand-over
		// ****************************************************************
		// a frame is read only after its toggle has settled, so both words stand still
		if (tog_chg) begin
			n.valid = 1'b1;
			n.gain_left = sdf_ramp(c.gain_left, tgt_l);
			n.gain_right = sdf_ramp(c.gain_right, tgt_r);
			n.out_left = c.bipolar_zero_code ? `SDF_BPZ : sdf_scale(b.left_smp, c.gain_left);
			n.out_right = c.bipolar_zero_code ? `SDF_BPZ : sdf_scale(b.right_smp, c.gain_right);
		end
		if (!rst_n) begin
			n = '0;
			n.left_steps = `SDF_STEPS_RST;
			n.right_steps = `SDF_STEPS_RST;
			n.act_left = `SDF_STEPS_RST;
			n.act_right = `SDF_STEPS_RST;
			n.ctl2 = `SDF_CTL2_RST;
			n.ctl3 = `SDF_CTL3_RST;
			n.align = align_locked;
			n.bipolar_zero_code = 1'b1;
			n.zero_oe_n = 1'b1;
			// control pins idle high; starting the synchronisers there avoids a false shift edge
			n.mc_s1 = 1'b1;
			n.mc_s2 = 1'b1;
			n.mc_d = 1'b1;
			n.md_s1 = 1'b1;
			n.md_s2 = 1'b1;
			n.ml_s1 = 1'b1;
			n.ml_s2 = 1'b1;
			n.ml_d = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		c <= n;
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign left_sample = c.out_left;
	assign right_sample = c.out_right;
	assign sample_valid = c.valid;
	assign bipolar_zero_hold = c.bipolar_zero_code;
	assign modulator_connected = c.mod_conn;
	assign soft_mute = c.ctl2[`SDF_R2_MUTE];
	assign deemph_select = {c.ctl2[`SDF_R2_DM_HI], c.ctl2[`SDF_R2_DM_LO]};
	assign sysclk_384 = c.sysclk_384;
	assign resync_active = (c.align == align_resync);
	// open drain: only ever pulls low
	assign zero_flag_out = 1'b0;
	assign zero_flag_oe_n = c.zero_oe_n;

endmodule : sdf_front_end
`default_nettype wire

// ---- sim/sdf_front_end_asserts.sv ----
// checker on the front end ports
`timescale 1ns/1ps
`default_nettype none
module sdf_chk #(
	parameter int ZERO_RUN = 65536
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic external_reset_n,
	input wire logic control_latch,
	input wire sdf_pkg::sdf_sample_t left_sample,
	input wire sdf_pkg::sdf_sample_t right_sample,
	input wire logic sample_valid,
	input wire logic bipolar_zero_hold,
	input wire logic modulator_connected,
	input wire logic soft_mute,
	input wire logic [1:0] deemph_select,
	input wire logic resync_active,
	input wire logic zero_flag_out,
	input wire logic zero_flag_oe_n
);
	import sdf_pkg::*;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	// ********
	// port relations
	// ********
	// the pin passes a two stage sync, so four low samples leave margin
	chk_pin_reset: assert property (!external_reset_n [*4] |=> bipolar_zero_hold && !modulator_connected)
		else $error("reset pin low did not hold the output");
	chk_resync_zero: assert property (resync_active |-> ##[0:1] bipolar_zero_hold)
		else $error("realign without bipolar zero");
	chk_flag_drive: assert property (zero_flag_out == 1'b0)
		else $error("zero flag drives high");
	chk_disc_zero: assert property (!modulator_connected |-> bipolar_zero_hold)
		else $error("modulator off without bipolar zero");
	chk_valid_pulse: assert property (sample_valid |=> !sample_valid)
		else $error("sample valid longer than one cycle");
	chk_sample_hold: assert property (!sample_valid |-> $stable(left_sample) && $stable(right_sample))
		else $error("samples moved without valid");
	chk_flag_release: assert property (sample_valid && left_sample != 18'h00000 |-> ##[0:2] zero_flag_oe_n)
		else $error("zero flag kept on nonzero data");
	chk_hold_mutes: assert property (bipolar_zero_hold [*8] ##1 sample_valid |-> left_sample == 18'h00000)
		else $error("held output carries data");
	chk_ctl_latch: assert property ($changed(soft_mute) || $changed(deemph_select) |-> !$past(control_latch, 2))
		else $error("control change without latch");
	cover property (sample_valid);
	cover property (resync_active);
	cover property (!zero_flag_oe_n);
	cover property (soft_mute);
endmodule : sdf_chk
bind sdf_front_end sdf_chk #(.ZERO_RUN(ZERO_RUN)) u_chk (.*);
`default_nettype wire

// ---- sim/sdf_src.sv ----
// audio source and control port master facing the front end
`timescale 1ns/1ps
`default_nettype none
module sdf_src (
	output logic bit_clock_in,
	output logic word_clock_in,
	output logic audio_data_in,
	output logic crystal_in,
	output logic control_shift_clock,
	output logic control_serial_data,
	output logic control_latch
);
	import sdf_pkg::*;
	logic [17:0] l_word;
	logic [17:0] r_word;
	logic [17:0] w;
	int wlen;
	int p;
	logic fmt;
	initial begin
		{bit_clock_in, crystal_in, word_clock_in, audio_data_in} = 4'h0;
		fmt = 1'b0;
		{control_shift_clock, control_serial_data, control_latch} = 3'h7;
		{l_word, r_word} = 36'h0;
		wlen = 16;
	end
	// ********
	// audio frames
	// ********
	// crystal at 256 fs, locked in phase to the bit clock
	always #15.625 crystal_in = ~crystal_in;
	always #62.5 bit_clock_in = ~bit_clock_in;
	// frames run without gaps so the clock check stays locked
	always begin
		for (int i = 0; i < 64; i++) begin
			@(negedge bit_clock_in);
			p = i % 32;
			w = i < 32 ? l_word : r_word;
			// I2S puts left on the low half and the msb one bit after the edge
			word_clock_in = (i < 32) ^ fmt;
			if (fmt) begin
				audio_data_in = (p >= 1 && p <= wlen) ? w[wlen - p] : ~audio_data_in;
			end else begin
				audio_data_in = (p >= 32 - wlen) ? w[31 - p] : ~audio_data_in;
			end
		end
	end
	// ********
	// control port
	// ********
	task automatic ctl(input logic [15:0] word);
		for (int b = 15; b >= 0; b--) begin
			control_shift_clock = 1'b0;
			control_serial_data = word[b];
			#40 control_shift_clock = 1'b1;
			#40;
		end
		control_serial_data = 1'b1;
		control_latch = 1'b0;
		#80 control_latch = 1'b1;
		#40;
	endtask : ctl
endmodule : sdf_src
`default_nettype wire

// ---- sim/tb_top.sv ----
// testbench: control rows, scaling, force, zero flag, reset pin
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import sdf_pkg::*;
	typedef struct packed {
		logic [15:0] word;
		logic [2:0] res;
	} sdf_row_t;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic external_reset_n = 1'b1;
	wire logic bit_clock_in, word_clock_in, audio_data_in, crystal_in;
	wire logic control_shift_clock, control_serial_data, control_latch;
	sdf_sample_t left_sample, right_sample;
	logic sample_valid, bipolar_zero_hold, modulator_connected, soft_mute;
	logic sysclk_384, resync_active, zero_flag_out, zero_flag_oe_n;
	logic [1:0] deemph_select;
	int miscompares = 0;
	int comparisons = 0;
	// reserved bits written as zero, result is {deemphasis, mute}
	sdf_row_t rows[5] = '{'{16'h0401, 3'h1}, '{16'h0402, 3'h2}, '{16'h0404, 3'h4},
		'{16'h0406, 3'h6}, '{16'h0400, 3'h0}};
	always #4 clk = ~clk;
	sdf_src i_src (
		.bit_clock_in(bit_clock_in),
		.word_clock_in(word_clock_in),
		.audio_data_in(audio_data_in),
		.crystal_in(crystal_in),
		.control_shift_clock(control_shift_clock),
		.control_serial_data(control_serial_data),
		.control_latch(control_latch)
	);
	sdf_front_end #(.ZERO_RUN(64)) i_dut (
		.clk(clk),
		.rst_n(rst_n),
		.bit_clock_in(bit_clock_in),
		.word_clock_in(word_clock_in),
		.audio_data_in(audio_data_in),
		.crystal_in(crystal_in),
		.control_shift_clock(control_shift_clock),
		.control_serial_data(control_serial_data),
		.control_latch(control_latch),
		.external_reset_n(external_reset_n),
		.left_sample(left_sample),
		.right_sample(right_sample),
		.sample_valid(sample_valid),
		.bipolar_zero_hold(bipolar_zero_hold),
		.modulator_connected(modulator_connected),
		.soft_mute(soft_mute),
		.deemph_select(deemph_select),
		.sysclk_384(sysclk_384),
		.resync_active(resync_active),
		.zero_flag_out(zero_flag_out),
		.zero_flag_oe_n(zero_flag_oe_n)
	);
	// ********
	// helpers
	// ********
	task automatic chk(input logic [17:0] got, input logic [17:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wrap_up;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : wrap_up
	// counts frames by the design's own valid pulse, bounded
	task automatic wait_sv(input int n);
		int k;
		k = 0;
		while (n > 0 && k < 30000) begin
			@(posedge clk);
			#1;
			k++;
			if (sample_valid === 1'b1)
				n--;
		end
		if (n > 0) begin
			miscompares++;
			wrap_up();
		end
	endtask : wait_sv
	// ********
	// sequence
	// ********
	initial begin
		// the link side resets only while bit clocks pass
		repeat (48) @(posedge clk);
		#1 rst_n = 1'b1;
		chk(18'({deemph_select, soft_mute, zero_flag_oe_n}), 18'h1);
		$display("reset test done");
		for (int i = 0; i < 5; i++) begin
			i_src.ctl(rows[i].word);
			chk(18'({deemph_select, soft_mute}), 18'(rows[i].res));
		end
		$display("control rows done");
		i_src.l_word = 18'h01000;
		i_src.r_word = 18'h3F000;
		i_src.ctl(16'h0004);
		i_src.ctl(16'h0304);
		wait_sv(10);
		chk(left_sample, 18'h00040);
		chk(right_sample, 18'h3FFC0);
		chk(18'({sysclk_384, modulator_connected}), 18'h1);
		i_src.ctl(16'h0401);
		wait_sv(8);
		chk(left_sample, 18'h0);
		$display("scaling test done");
		i_src.ctl(16'h0408);
		wait_sv(2);
		chk(18'({bipolar_zero_hold, modulator_connected}), 18'h2);
		i_src.ctl(16'h0410);
		i_src.l_word = 18'h0;
		i_src.r_word = 18'h0;
		wait_sv(4);
		chk(18'({zero_flag_oe_n, bipolar_zero_hold, modulator_connected}), 18'h2);
		i_src.l_word = 18'h01000;
		wait_sv(2);
		chk(18'({zero_flag_oe_n, bipolar_zero_hold, modulator_connected}), 18'h5);
		i_src.ctl(16'h0400);
		i_src.l_word = 18'h0;
		wait_sv(4);
		chk(18'({zero_flag_oe_n, bipolar_zero_hold, modulator_connected}), 18'h1);
		$display("zero flag test done");
		@(posedge clk);
		#1 external_reset_n = 1'b0;
		i_src.ctl(16'h0401);
		chk(18'({soft_mute, bipolar_zero_hold, modulator_connected}), 18'h2);
		@(posedge clk);
		#1 external_reset_n = 1'b1;
		$display("reset pin test done");
		i_src.ctl(16'h0605);
		i_src.fmt = 1'b1;
		i_src.wlen = 18;
		i_src.l_word = 18'h10000;
		i_src.r_word = 18'h3F000;
		wait_sv(6);
		chk(left_sample, 18'h00400);
		chk(right_sample, 18'h3FFC0);
		i_src.ctl(16'h0108);
		i_src.ctl(16'h060D);
		wait_sv(8);
		chk(left_sample, 18'h00800);
		chk(right_sample, 18'h3FF80);
		$display("format test done");
		wrap_up();
	end
endmodule : tb_top
`default_nettype wire
